/* include/acu_consts.vh */
`ifndef ACU_CONSTS_VH
`define ACU_CONSTS_VH

// ********************************************
// Word formats
// ********************************************
// Instruction word: indirect flag, function code, memory address
`define ACU_IND_BIT   15
`define ACU_OP_HI     14
`define ACU_OP_LO     12
`define ACU_ADDR_HI   11
`define ACU_ADDR_LO   0
`define ACU_ADDR_W    12
// Indirect address word: further-indirection flag, 15-bit address
`define ACU_IADR_HI   14
`define ACU_IADR_LO   0
// Data word: sign bit on top of 15 magnitude bits
`define ACU_SIGN_BIT  15
// Operate-group subfields
`define ACU_SUB_HI    11
`define ACU_SUB_LO    8
`define ACU_DEV_HI    7
`define ACU_DEV_LO    4
`define ACU_CNT_HI    3
`define ACU_CNT_LO    0

// ********************************************
// Function codes
// ********************************************
`define ACU_OP_LOAD   3'h0
`define ACU_OP_JUMP   3'h1
`define ACU_OP_CALL   3'h2
`define ACU_OP_ADD    3'h3
`define ACU_OP_AND    3'h4
`define ACU_OP_STORE  3'h5
`define ACU_OP_INCSZ  3'h6
`define ACU_OP_OPER   3'h7

// ********************************************
// Operate-group subcodes
// ********************************************
`define ACU_SUB_CLEAR 4'h0
`define ACU_SUB_NEG   4'h1
`define ACU_SUB_ROT   4'h2
`define ACU_SUB_SHL   4'h3
`define ACU_SUB_SZ    4'h4
`define ACU_SUB_SNZ   4'h5
`define ACU_SUB_SBS   4'h6
`define ACU_SUB_SBC   4'h7
`define ACU_SUB_SNO   4'h8
`define ACU_SUB_SENSE 4'h9
`define ACU_SUB_DIN   4'ha
`define ACU_SUB_DOUT  4'hb

// ********************************************
// Reset values
// ********************************************
`define ACU_PC_RST    15'h0000
`define ACU_ACC_RST   16'h0000

`endif

/* design/acu_core.v */
`include "acu_consts.vh"

// Notes on behaviour
// - Instruction splits into flag, code, address
// - Indirect word: 15-bit address, chaining flag
// - Data word is sign plus fifteen bits
// - Sixteen-bit words, two's complement arithmetic
// - Clear zeroes accumulator; load copies memory
// - Add sums memory in; store writes accumulator
// - AND memory word into accumulator
// - Negate replaces accumulator with two's complement
// - Rotate or shift left by count
// - Skip on accumulator zero or nonzero
// - Skip on the one count-selected bit set/clear
// - Skip when overflow indicator is clear
// - Sense skip samples addressed device line
// - Sense line true means skip next
// - Device input moves one word in
// - Device output sends one accumulator word
// - Device address field selects the peripheral
// - Jump loads program counter unconditionally
// - Call writes return address to memory
// - Increment happens in memory, in place
// - Increment: write back, accumulator, skip zero
// - Call stores address+1 at A, runs A+1
// - Bit 0 is MSB, bit 15 LSB
// - Overflow set by add, held until add/increment/clear
module acu_core #(
  parameter DATA_W = 16,
  parameter ADDR_W = 15,
  parameter DEV_N  = 16,
  parameter FUNC_W = 4,
  parameter DEV_W  = 4
) (
  input  wire              clk,
  input  wire              sys_rst,
  input  wire [DATA_W-1:0] memRdata,
  input  wire [DATA_W-1:0] ioDataIn,
  input  wire [DEV_N-1:0]  senseLines,
  output reg  [ADDR_W-1:0] memAddr_r,
  output reg               memRd_r,
  output reg               memWr_r,
  output reg  [DATA_W-1:0] memWdata_r,
  output reg  [DATA_W-1:0] ioDataOut_r,
  output reg  [DEV_W-1:0]  devAddr_r,
  output reg  [FUNC_W-1:0] devFunc_r,
  output reg               inStrobe_r,
  output reg               outStrobe_r,
  output reg  [DATA_W-1:0] acc_r,
  output reg               ovf_r,
  output reg  [ADDR_W-1:0] pc_r
);

  // ********************************************
  // Sequencer states
  // ********************************************
  localparam [7:0] ST_FETCH  = 8'h01;
  localparam [7:0] ST_RD1    = 8'h02;
  localparam [7:0] ST_RD2    = 8'h04;
  localparam [7:0] ST_DECODE = 8'h08;
  localparam [7:0] ST_INDIR  = 8'h10;
  localparam [7:0] ST_EXEC   = 8'h20;
  localparam [7:0] ST_OPER   = 8'h40;
  localparam [7:0] ST_IOIN   = 8'h80;

  reg [7:0]        state_r;
  reg [7:0]        ret_r;
  reg [DATA_W-1:0] ir_r;
  reg [DATA_W-1:0] rdata_r;
  reg [ADDR_W-1:0] ea_r;
  reg [DEV_N-1:0]  senseMeta_r;
  reg [DEV_N-1:0]  senseMid_r;
  reg [DEV_N-1:0]  senseLate_r;
  reg [DEV_N-1:0]  senseStable_r;

  // ********************************************
  // Decoded fields and datapath helpers
  // ********************************************
  wire [2:0]          opField   = ir_r[`ACU_OP_HI:`ACU_OP_LO];
  wire [3:0]          subField  = ir_r[`ACU_SUB_HI:`ACU_SUB_LO];
  wire [DEV_W-1:0]    devField  = ir_r[`ACU_DEV_HI:`ACU_DEV_LO];
  wire [3:0]          cntField  = ir_r[`ACU_CNT_HI:`ACU_CNT_LO];
  wire [2:0]          opRaw     = rdata_r[`ACU_OP_HI:`ACU_OP_LO];
  wire [ADDR_W-1:0]   rawAddr   = {{(ADDR_W-`ACU_ADDR_W){1'b0}},
                                   rdata_r[`ACU_ADDR_HI:`ACU_ADDR_LO]};
  wire [ADDR_W-1:0]   indAddr   = rdata_r[`ACU_IADR_HI:`ACU_IADR_LO];
  wire [ADDR_W-1:0]   pcInc     = pc_r + 1'b1;
  wire [ADDR_W-1:0]   eaInc     = ea_r + 1'b1;

  reg  [DATA_W-1:0]   sumAdd;
  reg                 addOvf;
  reg  [DATA_W-1:0]   incSum;
  reg  [2*DATA_W-1:0] rotWide;
  reg  [DATA_W-1:0]   bitProbe;
  reg                 skipHit;

  // Arithmetic, rotation and skip condition from current registers
  always @*
  begin
    sumAdd   = acc_r + rdata_r;
    // Signed overflow: like signs in, other sign out
    addOvf   = (acc_r[`ACU_SIGN_BIT] == rdata_r[`ACU_SIGN_BIT]) &&
               (sumAdd[`ACU_SIGN_BIT] != acc_r[`ACU_SIGN_BIT]);
    incSum   = rdata_r + 1'b1;
    rotWide  = {acc_r, acc_r} << cntField;
    // Bit 0 is the top bit, so shift the chosen bit up to the sign place
    bitProbe = acc_r << cntField;
    case (subField)
      `ACU_SUB_SZ:    skipHit = (acc_r == {DATA_W{1'b0}});
      `ACU_SUB_SNZ:   skipHit = (acc_r != {DATA_W{1'b0}});
      `ACU_SUB_SBS:   skipHit = bitProbe[DATA_W-1];
      `ACU_SUB_SBC:   skipHit = ~bitProbe[DATA_W-1];
      `ACU_SUB_SNO:   skipHit = ~ovf_r;
      `ACU_SUB_SENSE: skipHit = senseStable_r[devField];
      default:        skipHit = 1'b0;
    endcase
  end

  // ********************************************
  // Sense line synchroniser
  // ********************************************
  // Three stages; the filtered copy only follows once the last two agree,
  // so a line that changes near an edge never yields a one-cycle glitch.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      senseMeta_r   <= {DEV_N{1'b0}};
      senseMid_r    <= {DEV_N{1'b0}};
      senseLate_r   <= {DEV_N{1'b0}};
      senseStable_r <= {DEV_N{1'b0}};
    end
    else
    begin
      senseMeta_r   <= senseLines;
      senseMid_r    <= senseMeta_r;
      senseLate_r   <= senseMid_r;
      senseStable_r <= (senseMid_r & senseLate_r) |
                       (senseStable_r & (senseMid_r | senseLate_r));
    end
  end

  // ********************************************
  // Instruction sequencer
  // ********************************************
  // Memory is synchronous: a read seen in one cycle returns data the next.
  // Memory requests and the output strobe are one-cycle pulses cleared by default; the input strobe is cleared in ST_IOIN.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r     <= ST_FETCH;
      ret_r       <= ST_FETCH;
      ir_r        <= {DATA_W{1'b0}};
      rdata_r     <= {DATA_W{1'b0}};
      ea_r        <= {ADDR_W{1'b0}};
      memAddr_r   <= {ADDR_W{1'b0}};
      memRd_r     <= 1'b0;
      memWr_r     <= 1'b0;
      memWdata_r  <= {DATA_W{1'b0}};
      ioDataOut_r <= {DATA_W{1'b0}};
      devAddr_r   <= {DEV_W{1'b0}};
      devFunc_r   <= {FUNC_W{1'b0}};
      inStrobe_r  <= 1'b0;
      outStrobe_r <= 1'b0;
      acc_r       <= `ACU_ACC_RST;
      ovf_r       <= 1'b0;
      pc_r        <= `ACU_PC_RST;
    end
    else
    begin
      memRd_r     <= 1'b0;
      memWr_r     <= 1'b0;
      outStrobe_r <= 1'b0;
      case (state_r)
        // Read the instruction at the program counter
        ST_FETCH:
        begin
          memAddr_r <= pc_r;
          memRd_r   <= 1'b1;
          ret_r     <= ST_DECODE;
          state_r   <= ST_RD1;
        end
        // Memory samples the request during this cycle
        ST_RD1:
        begin
          state_r <= ST_RD2;
        end
        // Data valid now; capture and resume the caller
        ST_RD2:
        begin
          rdata_r <= memRdata;
          state_r <= ret_r;
        end
        // Latch the word, step the counter, start indirection if flagged and not an operate word
        ST_DECODE:
        begin
          ir_r <= rdata_r;
          pc_r <= pcInc;
          if (rdata_r[`ACU_IND_BIT] && (opRaw != `ACU_OP_OPER))
          begin
            memAddr_r <= rawAddr;
            memRd_r   <= 1'b1;
            ret_r     <= ST_INDIR;
            state_r   <= ST_RD1;
          end
          else
          begin
            ea_r    <= rawAddr;
            state_r <= ST_EXEC;
          end
        end
        // A self-referencing chain never ends; software must avoid it
        ST_INDIR:
        begin
          if (rdata_r[`ACU_IND_BIT])
          begin
            memAddr_r <= indAddr;
            memRd_r   <= 1'b1;
            ret_r     <= ST_INDIR;
            state_r   <= ST_RD1;
          end
          else
          begin
            ea_r    <= indAddr;
            state_r <= ST_EXEC;
          end
        end
        // Act on the effective address or on the accumulator alone
        ST_EXEC:
        begin
          state_r <= ST_FETCH;
          case (opField)
            `ACU_OP_LOAD, `ACU_OP_ADD, `ACU_OP_AND, `ACU_OP_INCSZ:
            begin
              memAddr_r <= ea_r;
              memRd_r   <= 1'b1;
              ret_r     <= ST_OPER;
              state_r   <= ST_RD1;
            end
            `ACU_OP_JUMP:
            begin
              pc_r <= ea_r;
            end
            `ACU_OP_CALL:
            begin
              // Return link goes to memory, so the caller may sit in ROM
              memAddr_r  <= ea_r;
              memWdata_r <= {{(DATA_W-ADDR_W){1'b0}}, pc_r};
              memWr_r    <= 1'b1;
              pc_r       <= eaInc;
              acc_r      <= {DATA_W{1'b0}};
            end
            `ACU_OP_STORE:
            begin
              memAddr_r  <= ea_r;
              memWdata_r <= acc_r;
              memWr_r    <= 1'b1;
            end
            `ACU_OP_OPER:
            begin
              case (subField)
                `ACU_SUB_CLEAR:
                begin
                  acc_r <= {DATA_W{1'b0}};
                  ovf_r <= 1'b0;
                end
                `ACU_SUB_NEG:
                begin
                  acc_r <= ~acc_r + 1'b1;
                end
                `ACU_SUB_ROT:
                begin
                  acc_r <= rotWide[2*DATA_W-1:DATA_W];
                end
                `ACU_SUB_SHL:
                begin
                  acc_r <= acc_r << cntField;
                end
                `ACU_SUB_SZ, `ACU_SUB_SNZ, `ACU_SUB_SBS, `ACU_SUB_SBC,
                `ACU_SUB_SNO, `ACU_SUB_SENSE:
                begin
                  if (skipHit)
                  begin
                    pc_r <= pcInc;
                  end
                end
                `ACU_SUB_DIN:
                begin
                  devAddr_r  <= devField;
                  devFunc_r  <= cntField;
                  inStrobe_r <= 1'b1;
                  state_r    <= ST_IOIN;
                end
                `ACU_SUB_DOUT:
                begin
                  devAddr_r   <= devField;
                  devFunc_r   <= cntField;
                  ioDataOut_r <= acc_r;
                  outStrobe_r <= 1'b1;
                end
                default:
                begin
                  // Unused operate codes fall through as no-operation
                  acc_r <= acc_r;
                end
              endcase
            end
            default:
            begin
              state_r <= ST_FETCH;
            end
          endcase
        end
        // Operand arrived; finish the memory-reference instruction
        ST_OPER:
        begin
          state_r <= ST_FETCH;
          case (opField)
            `ACU_OP_LOAD:
            begin
              acc_r <= rdata_r;
            end
            `ACU_OP_ADD:
            begin
              acc_r <= sumAdd;
              ovf_r <= addOvf;
            end
            `ACU_OP_AND:
            begin
              acc_r <= acc_r & rdata_r;
            end
            `ACU_OP_INCSZ:
            begin
              // Counting stays in the memory word, so many indexes coexist
              memAddr_r  <= ea_r;
              memWdata_r <= incSum;
              memWr_r    <= 1'b1;
              acc_r      <= incSum;
              ovf_r      <= (incSum == {DATA_W{1'b0}});
              if (incSum == {DATA_W{1'b0}})
              begin
                pc_r <= pcInc;
              end
            end
            default:
            begin
              state_r <= ST_FETCH;
            end
          endcase
        end
        // Peripheral drives its word while the input strobe is high
        ST_IOIN:
        begin
          acc_r      <= ioDataIn;
          inStrobe_r <= 1'b0;
          state_r    <= ST_FETCH;
        end
        default:
        begin
          state_r <= ST_FETCH;
        end
      endcase
    end
  end

endmodule

/* testbench/acu_core_sva.sv */
// ****************
// Port checker
// ****************
module acu_core_sva #(
  parameter DATA_W = 16,
  parameter ADDR_W = 15,
  parameter DEV_N  = 16,
  parameter FUNC_W = 4,
  parameter DEV_W  = 4
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [DATA_W-1:0] memRdata,
  input wire logic [DATA_W-1:0] ioDataIn,
  input wire logic [DEV_N-1:0]  senseLines,
  input wire logic [ADDR_W-1:0] memAddr_r,
  input wire logic              memRd_r,
  input wire logic              memWr_r,
  input wire logic [DATA_W-1:0] memWdata_r,
  input wire logic [DATA_W-1:0] ioDataOut_r,
  input wire logic [DEV_W-1:0]  devAddr_r,
  input wire logic [FUNC_W-1:0] devFunc_r,
  input wire logic              inStrobe_r,
  input wire logic              outStrobe_r,
  input wire logic [DATA_W-1:0] acc_r,
  input wire logic              ovf_r,
  input wire logic [ADDR_W-1:0] pc_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clocking and reset are stated once
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_in_capture: assert property (inStrobe_r |=> acc_r == $past(ioDataIn))
    else $error("input word not captured into accumulator");
  a_in_pulse: assert property (inStrobe_r |=> !inStrobe_r)
    else $error("input strobe longer than one cycle");
  a_out_pulse: assert property (outStrobe_r |=> !outStrobe_r)
    else $error("output strobe longer than one cycle");
  a_out_data: assert property (outStrobe_r |-> ioDataOut_r == acc_r)
    else $error("output word differs from accumulator");
  a_out_hold: assert property ($changed(ioDataOut_r) |-> outStrobe_r)
    else $error("output word moved without a strobe");
  a_dev_hold: assert property ($changed(devAddr_r) |-> inStrobe_r || outStrobe_r)
    else $error("device address moved without a transfer");
  a_wr_no_rd: assert property (memWr_r |-> !memRd_r)
    else $error("memory read and write together");
  a_rd_spacing: assert property (memRd_r |=> !memRd_r [*2])
    else $error("memory reads closer than three cycles");
  a_reset_fetch: assert property ($fell(sys_rst) |=> memRd_r && memAddr_r == '0)
    else $error("first fetch not from address zero");

  c_input: cover property (inStrobe_r);
  c_output: cover property (outStrobe_r);
  c_write: cover property (memWr_r ##1 !memWr_r);
endmodule

bind acu_core acu_core_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .DEV_N(DEV_N),
  .FUNC_W(FUNC_W), .DEV_W(DEV_W)) i_sva (.clk(clk), .sys_rst(sys_rst),
  .memRdata(memRdata), .ioDataIn(ioDataIn), .senseLines(senseLines),
  .memAddr_r(memAddr_r), .memRd_r(memRd_r), .memWr_r(memWr_r),
  .memWdata_r(memWdata_r), .ioDataOut_r(ioDataOut_r), .devAddr_r(devAddr_r),
  .devFunc_r(devFunc_r), .inStrobe_r(inStrobe_r), .outStrobe_r(outStrobe_r),
  .acc_r(acc_r), .ovf_r(ovf_r), .pc_r(pc_r));

/* testbench/acu_periph.sv */
// ****************
// Peripheral controllers on the I/O bus
// ****************
module acu_periph (
  input  wire logic        clk,
  input  wire logic [3:0]  devAddr,
  input  wire logic        inStrobe,
  input  wire logic        outStrobe,
  input  wire logic [15:0] ioDataOut,
  input  wire logic        cfgEn,
  input  wire logic [3:0]  cfgDev,
  input  wire logic [15:0] cfgWord,
  input  wire logic [15:0] cfgSense,
  output wire logic [15:0] ioDataIn,
  output wire logic [15:0] senseLines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word [16];
  logic [15:0] lastIn_r = 16'h0000;

  // Distinct power-up words so a wrong device is caught
  initial
  begin
    for (int i = 0; i < 16; i++)
      word[i] = 16'h5a5a ^ 16'(i * 16'h1111);
  end

  // Each slot answers and stores only for its own address
  always @(posedge clk)
  begin
    if (cfgEn)
      word[cfgDev] <= cfgWord;
    if (outStrobe)
      word[devAddr] <= ioDataOut;
    lastIn_r <= ioDataIn;
  end

  // Idle bus toggles every cycle, never holds a stale word
  assign ioDataIn = inStrobe ? word[devAddr] : ~lastIn_r;
  // Sense levels come straight from the cfgSense input
  assign senseLines = cfgSense;
endmodule

/* testbench/acu_core_bench.sv */
`include "acu_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h expected %h", $time, g, e); end end

module acu_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic [15:0] memRdata = 16'h0000;
  logic        cfgEn = 0;
  logic [3:0]  cfgDev = 4'h0;
  logic [15:0] cfgWord = 16'h0000;
  logic [15:0] cfgSense = 16'h0000;
  wire  [15:0] ioDataIn, senseLines, memWdata_r, ioDataOut_r, acc_r;
  wire  [14:0] memAddr_r, pc_r;
  wire  [3:0]  devAddr_r, devFunc_r;
  wire         memRd_r, memWr_r, inStrobe_r, outStrobe_r, ovf_r;
  logic [15:0] mem [0:4095];
  logic [31:0] expQ [$];
  logic [15:0] accM;
  logic        ovfM;
  int          n_errors = 0;
  int          n_tests = 0;
  int          wp, dp, op;

  acu_core i_dut (.clk(clk), .sys_rst(sys_rst), .memRdata(memRdata), .ioDataIn(ioDataIn),
    .senseLines(senseLines), .memAddr_r(memAddr_r), .memRd_r(memRd_r), .memWr_r(memWr_r),
    .memWdata_r(memWdata_r), .ioDataOut_r(ioDataOut_r), .devAddr_r(devAddr_r),
    .devFunc_r(devFunc_r), .inStrobe_r(inStrobe_r), .outStrobe_r(outStrobe_r),
    .acc_r(acc_r), .ovf_r(ovf_r), .pc_r(pc_r));
  acu_periph i_periph (.clk(clk), .devAddr(devAddr_r), .inStrobe(inStrobe_r),
    .outStrobe(outStrobe_r), .ioDataOut(ioDataOut_r), .cfgEn(cfgEn), .cfgDev(cfgDev),
    .cfgWord(cfgWord), .cfgSense(cfgSense), .ioDataIn(ioDataIn), .senseLines(senseLines));

  always #10 clk = ~clk;

  // Sync memory, one cycle latency; idle read bus toggles
  always @(posedge clk)
  begin
    if (memWr_r === 1'b1)
      mem[memAddr_r[11:0]] <= memWdata_r;
    memRdata <= (memRd_r === 1'b1) ? mem[memAddr_r[11:0]] : ~memRdata;
  end

  // ****************
  // Program builder
  // ****************
  function logic [15:0] ins(input logic [2:0] f, input int a);
    return {1'b0, f, a[11:0]};
  endfunction
  function logic [15:0] opr(input logic [3:0] s, input logic [3:0] d, input logic [3:0] c);
    return {1'b0, `ACU_OP_OPER, s, d, c};
  endfunction
  task put(input logic [15:0] w);
    mem[wp] = w;
    wp++;
  endtask
  task dat(input logic [15:0] v, output int a);
    a = dp;
    mem[dp] = v;
    dp++;
  endtask
  task expw(input logic k, input int a, input logic [15:0] d);
    expQ.push_back({k, a[14:0], d});
  endtask
  // A store makes the accumulator visible as a memory write
  task sto;
    put(ins(`ACU_OP_STORE, op));
    expw(0, op, accM);
    op++;
  endtask
  // A skipped store must never reach memory
  task skp(input logic [15:0] w, input bit take);
    put(w);
    put(ins(`ACU_OP_STORE, op));
    if (!take)
      expw(0, op, accM);
    op++;
  endtask
  task ld(input logic [15:0] v);
    int a;
    dat(v, a);
    put(ins(`ACU_OP_LOAD, a));
    accM = v;
  endtask
  task start;
    sys_rst <= 1;
    @(posedge clk);
    wp = 0;
    dp = 'h200;
    op = 'h300;
    accM = 16'h0000;
  endtask
  // Release reset, let the program end in its self-jump
  task run(input string nm);
    put(ins(`ACU_OP_JUMP, wp));
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    for (int k = 0; k < 3000 && expQ.size() > 0; k++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    if (expQ.size() != 0)
    begin
      n_errors++;
      $display("BAD %0t %s missing %0d results", $time, nm, expQ.size());
      expQ.delete();
    end
    $display("test %s ended, errors %0d", nm, n_errors);
  endtask
  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************
  // Result watcher
  // ****************
  always @(posedge clk)
  begin : watch
    logic [31:0] got;
    logic [31:0] want;
    if (sys_rst === 1'b0 && (memWr_r === 1'b1 || outStrobe_r === 1'b1))
    begin
      got = outStrobe_r ? {1'b1, 7'h00, devFunc_r, devAddr_r, ioDataOut_r}
                        : {1'b0, memAddr_r, memWdata_r};
      if (expQ.size() == 0)
      begin
        n_errors++;
        $display("BAD %0t unexpected write %h", $time, got);
      end
      else
      begin
        want = expQ.pop_front();
        `CHK(got, want)
      end
    end
  end

  // Four short programs take well under 20000 cycles
  initial
  begin
    #400000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish;
  end

  // ****************
  // Tests
  // ****************
  initial
  begin
    logic [15:0] a, b, v;
    logic [3:0] n, d, e;
    int t, q, p;
    void'($urandom(32'h3555));
    start;
    a = $urandom;
    b = $urandom;
    n = $urandom;
    ld(a);
    sto;
    dat(b, t);
    put(ins(`ACU_OP_ADD, t));
    v = a + b;
    ovfM = (a[15] == b[15]) && (v[15] != a[15]);
    accM = v;
    sto;
    skp(opr(`ACU_SUB_SNO, 0, 0), !ovfM);
    dat(~b, t);
    put(ins(`ACU_OP_AND, t));
    accM = accM & ~b;
    sto;
    put(opr(`ACU_SUB_NEG, 0, 0));
    accM = -accM;
    sto;
    put(opr(`ACU_SUB_ROT, 0, n));
    accM = (accM << n) | (accM >> (16 - n));
    sto;
    put(opr(`ACU_SUB_SHL, 0, n));
    accM = accM << n;
    sto;
    skp(opr(`ACU_SUB_SNO, 0, 0), !ovfM);
    put(opr(`ACU_SUB_CLEAR, 0, 0));
    accM = 16'h0000;
    sto;
    skp(opr(`ACU_SUB_SNO, 0, 0), 1);
    run("data");
    start;
    v = $urandom;
    ld(v);
    skp(opr(`ACU_SUB_SZ, 0, 0), v == 0);
    skp(opr(`ACU_SUB_SNZ, 0, 0), v != 0);
    for (int i = 0; i < 16; i++)
    begin
      skp(opr(`ACU_SUB_SBS, 0, 4'(i)), v[15-i]);
      skp(opr(`ACU_SUB_SBC, 0, 4'(i)), !v[15-i]);
    end
    for (int s = 12; s < 16; s++)
    begin
      put(opr(4'(s), 4'h3, 4'h5));
      sto;
    end
    ld(16'h0000);
    skp(opr(`ACU_SUB_SZ, 0, 0), 1);
    skp(opr(`ACU_SUB_SNZ, 0, 0), 0);
    run("skips");
    start;
    d = $urandom;
    e = $urandom;
    n = $urandom;
    b = $urandom;
    cfgDev <= d;
    cfgWord <= b;
    cfgEn <= 1;
    cfgSense <= 16'h0001 << n;
    @(posedge clk);
    cfgEn <= 0;
    put(opr(`ACU_SUB_DIN, d, e));
    accM = b;
    sto;
    ld(a);
    put(opr(`ACU_SUB_DOUT, e, d));
    expw(1, {d, e}, a);
    // Read the word back from the device that just stored it
    put(opr(`ACU_SUB_DIN, e, d));
    accM = a;
    sto;
    skp(opr(`ACU_SUB_SENSE, n, 0), 1);
    skp(opr(`ACU_SUB_SENSE, n + 4'h1, 0), 0);
    run("io");
    start;
    // Jump over a stray load and a store that must never run
    put(ins(`ACU_OP_JUMP, wp + 3));
    skp(16'h0000, 1);
    p = wp;
    // Link slot sits apart from the call, so address and link differ
    put(ins(`ACU_OP_CALL, p + 2));
    put(16'h0000);
    put(16'h0000);
    expw(0, p + 2, 16'(p + 1));
    accM = 16'h0000;
    sto;
    // Wrapping increment skips the store right behind it
    dat(16'hffff, t);
    skp(ins(`ACU_OP_INCSZ, t), 1);
    expw(0, t, 16'h0000);
    v = $urandom % 16'hffff;
    dat(v, t);
    put(ins(`ACU_OP_INCSZ, t));
    accM = v + 1;
    expw(0, t, accM);
    sto;
    skp(opr(`ACU_SUB_SNO, 0, 0), 1);
    dat(a, t);
    dat(16'(t), q);
    dat(16'h8000 | 16'(q), t);
    put({1'b1, `ACU_OP_LOAD, 12'(t)});
    accM = a;
    sto;
    run("flow");
    tally_and_finish;
  end
endmodule
